// >>> tb/ppce_cmdr.sv
`timescale 1ns/1ns
`default_nettype none
module ppce_cmdr (
  input  wire logic       clk_sys_i,   // System clock.
  input  wire logic       cmd_ready_i, // Engine takes a command.
  output var  logic       cmd_valid_o, // Command present.
  output var  logic [4:0] cmd_op_o,    // Opcode.
  output var  logic [3:0] cmd_port_o,  // Port or location.
  output var  logic [6:0] cmd_idx_o,   // Bit or index.
  output var  logic [7:0] cmd_data_o,  // Value.
  output var  logic       cmd_io_o     // Direction flag.
);
  // Idle lines until the first command.
  initial begin
    {cmd_valid_o, cmd_op_o, cmd_port_o, cmd_idx_o, cmd_data_o, cmd_io_o} = 26'h0;
  end
  // Hold a command until ready is sampled high; on release port, index and data show their inverse so stale data is never trusted.
  // Scans are only run from the external source, since an internal one without a delay steps on every clock and outruns the TRG commands.
  task automatic send(input logic [4:0] o, input logic [3:0] p, input logic [6:0] i, input logic [7:0] d, input logic io);
    @(negedge clk_sys_i);
    {cmd_valid_o, cmd_op_o, cmd_port_o, cmd_idx_o, cmd_data_o, cmd_io_o} = {1'b1, o, p, i, d, io};
    @(posedge clk_sys_i);
    while (cmd_ready_i !== 1'b1) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    {cmd_valid_o, cmd_port_o, cmd_idx_o, cmd_data_o} = {1'b0, ~p, ~i, ~d};
  endtask
endmodule
`default_nettype wire

// >>> tb/ppce_engine_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppce_defs.vh"
module ppce_engine_sva (
  input wire logic        clk_sys_i,   // Clock.
  input wire logic        reset_i,     // Reset.
  input wire logic        cmd_valid_i, // Command present.
  input wire logic [4:0]  cmd_op_i,    // Opcode.
  input wire logic [3:0]  cmd_port_i,  // Port.
  input wire logic [6:0]  cmd_idx_i,   // Bit number.
  input wire logic        cmd_ready_o, // Ready.
  input wire logic        rsp_valid_o, // Answer pulse.
  input wire logic [7:0]  rsp_data_o,  // Answer.
  input wire logic [95:0] port_out_o,  // Port drive.
  input wire logic [31:0] elapsed_o,   // Elapsed count.
  input wire logic [23:0] loc_addr_i,  // Local address.
  input wire logic        loc_wr_i,    // Local write.
  input wire logic [7:0]  loc_wdata_i, // Local data.
  input wire logic        loc_ack_o,   // Local ack.
  input wire logic        loc_err_o    // Local error.
);
  logic [6:0] pos_r;
  logic [3:0] wpos_r;
  logic [7:0] wdat_r;
  wire        acc = cmd_valid_i && cmd_ready_o;
  wire        take = acc && (cmd_port_i < 4'hc);
  // Remember the bit and byte last addressed, so later cycles can be tied to them.
  always @(posedge clk_sys_i) begin
    if (acc) begin
      pos_r <= {cmd_port_i, 3'h0} + {4'h0, cmd_idx_i[2:0]};
    end
    wpos_r <= loc_addr_i[3:0];
    wdat_r <= loc_wdata_i;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_set_bit: assert property (take && cmd_op_i == `PPCE_OP_SETBIT |=> port_out_o[pos_r]) else $error("bit not set");
  a_clr_bit: assert property (take && cmd_op_i == `PPCE_OP_CLRBIT |=> !port_out_o[pos_r]) else $error("bit not clear");
  a_pulse_high: assert property (take && cmd_op_i == `PPCE_OP_PULSEHI |=> port_out_o[pos_r] && !cmd_ready_o ##1 !port_out_o[pos_r])
    else $error("high pulse shape wrong");
  a_pulse_low: assert property (take && cmd_op_i == `PPCE_OP_PULSELO |=> !port_out_o[pos_r] ##1 port_out_o[pos_r])
    else $error("low pulse shape wrong");
  a_time_zero: assert property (acc && cmd_op_i == `PPCE_OP_TIMERST |=> elapsed_o == 32'h0) else $error("time not zeroed");
  a_time_step: assert property (!(acc && (cmd_op_i == `PPCE_OP_TIMERST || cmd_op_i == `PPCE_OP_RST))
    |=> elapsed_o == $past(elapsed_o) + 32'h1) else $error("elapsed count stalled");
  a_sre_query: assert property (acc && cmd_op_i == `PPCE_OP_SRE_RD |=> rsp_valid_o && !rsp_data_o[6]) else $error("enable query wrong");
  a_size_answer: assert property (acc && cmd_op_i == `PPCE_OP_SSIZE |=> rsp_valid_o) else $error("size query silent");
  a_io_write: assert property (loc_wr_i && loc_addr_i[23:18] == 6'h1e && loc_addr_i[3:0] < 4'hc
    |=> loc_ack_o && !loc_err_o && port_out_o[{wpos_r, 3'h0} +: 8] == wdat_r) else $error("port write lost");
  a_rsv_error: assert property (loc_wr_i && loc_addr_i[23:21] == 3'h1 |=> loc_ack_o && loc_err_o) else $error("reserved not flagged");
endmodule
bind ppce_engine ppce_engine_sva ppce_engine_sva_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_port_i(cmd_port_i), .cmd_idx_i(cmd_idx_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o), .port_out_o(port_out_o), .elapsed_o(elapsed_o), .loc_addr_i(loc_addr_i), .loc_wr_i(loc_wr_i),
  .loc_wdata_i(loc_wdata_i), .loc_ack_o(loc_ack_o), .loc_err_o(loc_err_o));
`default_nettype wire

// >>> tb/ppce_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppce_defs.vh"
module ppce_engine_tb;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        nv_erase_i = 1'b1;
  logic [95:0] port_in_i = 96'h0;
  logic [7:0]  stb_i = 8'h0;
  logic [23:0] loc_addr_i = 24'h0;
  logic        loc_rd_i = 1'b0;
  logic        loc_wr_i = 1'b0;
  logic [7:0]  loc_wdata_i = 8'h0;
  wire         cmd_valid_i, cmd_io_i, cmd_ready_o, rsp_valid_o, loc_ack_o, loc_err_o, req_true_o;
  wire  [4:0]  cmd_op_i;
  wire  [3:0]  cmd_port_i;
  wire  [6:0]  cmd_idx_i;
  wire  [7:0]  cmd_data_i, rsp_data_o, loc_rdata_o, trig_out_o;
  wire  [95:0] port_out_o;
  wire  [31:0] elapsed_o;
  logic [95:0] m_port, m_nv0, m_nv3;
  logic [7:0]  m_res[$];
  logic [31:0] seed = 32'ha4c1c9ec;
  logic [31:0] r;
  logic [7:0]  v, rd;
  logic [4:0]  op;
  logic        er;
  int          p, error_cnt, compares, cycles;
  ppce_engine ppce_engine_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .nv_erase_i(nv_erase_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_port_i(cmd_port_i), .cmd_idx_i(cmd_idx_i), .cmd_data_i(cmd_data_i), .cmd_io_i(cmd_io_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .port_in_i(port_in_i),
    .port_out_o(port_out_o), .trig_in_i(8'h00), .trig_out_o(trig_out_o), .stb_i(stb_i), .req_true_o(req_true_o),
    .elapsed_o(elapsed_o), .loc_addr_i(loc_addr_i), .loc_rd_i(loc_rd_i), .loc_wr_i(loc_wr_i), .loc_wdata_i(loc_wdata_i),
    .loc_rdata_o(loc_rdata_o), .loc_ack_o(loc_ack_o), .loc_err_o(loc_err_o));
  ppce_cmdr ppce_cmdr_inst (.clk_sys_i(clk_sys_i), .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i),
    .cmd_port_o(cmd_port_i), .cmd_idx_o(cmd_idx_i), .cmd_data_o(cmd_data_i), .cmd_io_o(cmd_io_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clock; a cycle ceiling cuts a hang short.
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d, error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Command, then two cycles so pulses and loads have settled.
  task automatic cmd(input logic [4:0] o, input logic [3:0] pt, input logic [6:0] i, input logic [7:0] d, input logic io);
    ppce_cmdr_inst.send(o, pt, i, d, io);
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic q(input logic [4:0] o, input logic [3:0] pt, input logic [7:0] exp);
    ppce_cmdr_inst.send(o, pt, 7'h0, 8'h0, 1'b0);
    chk(rsp_valid_o, 1'b1);
    chk(rsp_data_o, exp);
  endtask
  task automatic loc(input logic wr, input logic [23:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {loc_addr_i, loc_wdata_i, loc_wr_i, loc_rd_i} = {a, d, wr, !wr};
    @(negedge clk_sys_i);
    {loc_addr_i, loc_wr_i, loc_rd_i} = {~a, 2'b00};
    chk(loc_ack_o, 1'b1);
    {rd, er} = {loc_rdata_o, loc_err_o};
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    port_in_i = {rnd(), rnd(), rnd()};
    repeat (10) @(negedge clk_sys_i);
    {reset_i, nv_erase_i, m_port} = 98'h0;
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      p = r[7:0] % 12;
      op = `PPCE_OP_SETBIT + {3'h0, r[9:8]};
      stb_i = r[31:24];
      cmd(op, p[3:0], {4'h0, r[14:12]}, 8'h0, 1'b0);
      m_port[p * 8 + r[14:12]] = (op == `PPCE_OP_SETBIT) || (op == `PPCE_OP_PULSELO);
      chk(port_out_o, m_port);
    end
    cmd(`PPCE_OP_SAVE, 4'h0, 7'h0, 8'h0, 1'b0);
    m_nv0 = m_port;
    for (p = 0; p < 12; p++) begin
      r = rnd();
      loc(1'b1, {20'h78000, p[3:0]}, r[7:0]);
      m_port[p * 8 +: 8] = r[7:0];
      chk({er, port_out_o}, {1'b0, m_port});
    end
    cmd(`PPCE_OP_SAVE, 4'h3, 7'h0, 8'h0, 1'b0);
    m_nv3 = m_port;
    loc(1'b1, 24'h200010, 8'h5a);
    chk({er, port_out_o}, {1'b1, m_port});
    loc(1'b0, 24'h780005, 8'h00);
    chk({er, rd}, {1'b0, port_in_i[47:40]});
    loc(1'b1, 24'h780002, 8'hff);
    cmd(`PPCE_OP_RECALL, 4'ha, 7'h0, 8'h0, 1'b0);
    m_port[23:16] = 8'hff;
    chk(port_out_o, m_port);
    cmd(`PPCE_OP_RECALL, 4'h3, 7'h0, 8'h0, 1'b0);
    m_port = m_nv3;
    chk(port_out_o, m_port);
    for (int n = 0; n < 6; n++) begin
      r = rnd();
      v = (n == 0) ? 8'hff : r[7:0];
      cmd(`PPCE_OP_SRE_WR, 4'h0, 7'h0, v, 1'b0);
      q(`PPCE_OP_SRE_RD, 4'h0, v & `PPCE_SRE_B6_MASK);
    end
    stb_i = 8'h40;
    cmd(`PPCE_OP_SRE_WR, 4'h0, 7'h0, 8'hff, 1'b0);
    stb_i = 8'h44;
    @(negedge clk_sys_i) chk(req_true_o, 1'b1);
    ppce_cmdr_inst.send(`PPCE_OP_TIMERST, 4'h0, 7'h0, 8'h0, 1'b0);
    chk(elapsed_o, 32'h0);
    cmd(`PPCE_OP_SSRC, 4'h0, 7'h0, 8'h01, 1'b0);
    cmd(`PPCE_OP_SLIST, 4'h1, 7'h0, 8'ha5, 1'b1);
    cmd(`PPCE_OP_SLIST, 4'h1, 7'h0, 8'h0f, 1'b0);
    cmd(`PPCE_OP_SBREAK, 4'h1, 7'h0, 8'h00, 1'b0);
    cmd(`PPCE_OP_SLIST, 4'h1, 7'h0, 8'h3c, 1'b1);
    for (p = 1; p < 5; p++) cmd(`PPCE_OP_SLIST, 4'h2, 7'h0, 8'h11 * p[7:0], 1'b1);
    cmd(`PPCE_OP_TRG, 4'h0, 7'h0, 8'h00, 1'b0);
    chk(port_out_o, m_port);
    cmd(`PPCE_OP_SCAN, 4'h0, 7'h0, `PPCE_SCAN_START, 1'b0);
    m_res.push_back(port_in_i[15:8] & 8'h0f);
    m_port[15:8] = 8'ha5;
    for (p = 1; p < 5; p++) begin
      cmd(`PPCE_OP_TRG, 4'h0, 7'h0, 8'h00, 1'b0);
      m_port[23:16] = 8'h11 * p[7:0];
      chk(port_out_o, m_port);
    end
    q(`PPCE_OP_SSIZE, 4'h1, m_res.size());
    q(`PPCE_OP_SREAD, 4'h1, m_res[0]);
    cmd(`PPCE_OP_SCAN, 4'h0, 7'h0, `PPCE_SCAN_START, 1'b0);
    cmd(`PPCE_OP_TRGOUT, 4'h5, 7'h0, 8'h00, 1'b0);
    ppce_cmdr_inst.send(`PPCE_OP_TRG, 4'h0, 7'h0, 8'h00, 1'b0);
    chk(trig_out_o, 8'h20);
    chk(port_out_o[15:8], 8'h3c);
    cmd(`PPCE_OP_SCLEAR, 4'h1, 7'h0, 8'h00, 1'b0);
    cmd(`PPCE_OP_SCAN, 4'h0, 7'h0, `PPCE_SCAN_CONT, 1'b0);
    cmd(`PPCE_OP_TRG, 4'h0, 7'h0, 8'h00, 1'b0);
    chk(port_out_o[15:8], 8'h3c);
    cmd(`PPCE_OP_RST, 4'h0, 7'h0, 8'h00, 1'b0);
    repeat (3) @(negedge clk_sys_i);
    cmd(`PPCE_OP_TRG, 4'h0, 7'h0, 8'h00, 1'b0);
    chk(port_out_o, m_nv0);
    summarize();
  end
endmodule
`default_nettype wire

// >>> verilog/ppce_addr_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "ppce_defs.vh"

module ppce_addr_dec (
  input  wire [23:0] addr_i,   // Local processor address.
  output reg  [3:0]  region_o  // Decoded region code.
);

  // ----------------------------------------------------------------
  // Region decode on 256 KB granules
  // ----------------------------------------------------------------
  // Reserved and unsupported holes decode to no region at all.
  always @* begin
    if (addr_i[23]) begin
      region_o = `PPCE_RG_USER;
    end else if (addr_i[23:18] <= `PPCE_A_ROM_TOP) begin
      region_o = `PPCE_RG_ROM;
    end else if (addr_i[23:18] <= `PPCE_A_RSV_TOP) begin
      region_o = `PPCE_RG_NONE;
    end else if (addr_i[23:18] <= `PPCE_A_RAM_TOP) begin
      region_o = `PPCE_RG_RAM;
    end else if (addr_i[23:18] <= `PPCE_A_NVM_TOP) begin
      region_o = `PPCE_RG_NVM;
    end else if (addr_i[23:18] == `PPCE_A_TMR) begin
      region_o = `PPCE_RG_TMR;
    end else if (addr_i[23:18] == `PPCE_A_IO) begin
      region_o = `PPCE_RG_IO;
    end else if (addr_i[23:18] == `PPCE_A_VXI) begin
      region_o = `PPCE_RG_VXI;
    end else begin
      region_o = `PPCE_RG_NONE;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/ppce_defs.vh
`ifndef PPCE_DEFS_VH
`define PPCE_DEFS_VH

// ----------------------------------------------------------------
// Command opcodes presented on cmd_op_i
// ----------------------------------------------------------------
`define PPCE_OP_SETBIT   5'h01
`define PPCE_OP_CLRBIT   5'h02
`define PPCE_OP_PULSEHI  5'h03
`define PPCE_OP_PULSELO  5'h04
`define PPCE_OP_RECALL   5'h05
`define PPCE_OP_SAVE     5'h06
`define PPCE_OP_RST      5'h07
`define PPCE_OP_TIMERST  5'h08
`define PPCE_OP_SCAN     5'h09
`define PPCE_OP_SBREAK   5'h0a
`define PPCE_OP_SLIST    5'h0b
`define PPCE_OP_SCLEAR   5'h0c
`define PPCE_OP_SREAD    5'h0d
`define PPCE_OP_SSIZE    5'h0e
`define PPCE_OP_SSRC     5'h0f
`define PPCE_OP_SRE_WR   5'h10
`define PPCE_OP_SRE_RD   5'h11
`define PPCE_OP_TRG      5'h12
`define PPCE_OP_TRGIN    5'h13
`define PPCE_OP_TRGOUT   5'h14
`define PPCE_OP_WAI      5'h15
`define PPCE_OP_OPT_WR   5'h16
`define PPCE_OP_OPT_RD   5'h17
`define PPCE_OP_TST      5'h18
`define PPCE_OP_DELAY    5'h19
`define PPCE_OP_OUTPORT  5'h1a

// ----------------------------------------------------------------
// Sizes and field values
// ----------------------------------------------------------------
`define PPCE_NPORT       12
`define PPCE_NLOC        10
`define PPCE_LOC_LAST    4'h9
`define PPCE_SL_DEPTH    4'h8
`define PPCE_OPT_LEN     7'h50
`define PPCE_SCAN_STOP   8'h00
`define PPCE_SCAN_START  8'h01
`define PPCE_SCAN_CONT   8'h02
`define PPCE_TRG_OFF     4'h8
`define PPCE_SRE_B6_MASK 8'hbf
`define PPCE_IO_OUT      1'b1
`define PPCE_SRC_EXT     1'b1
`define PPCE_TST_STEPS   3'h5

// ----------------------------------------------------------------
// Local address map, upper address bits A23..A18
// ----------------------------------------------------------------
`define PPCE_RG_ROM      4'h0
`define PPCE_RG_RAM      4'h1
`define PPCE_RG_NVM      4'h2
`define PPCE_RG_TMR      4'h3
`define PPCE_RG_IO       4'h4
`define PPCE_RG_VXI      4'h5
`define PPCE_RG_USER     4'h6
`define PPCE_RG_NONE     4'hf
`define PPCE_A_ROM_TOP   6'h07
`define PPCE_A_RSV_TOP   6'h0f
`define PPCE_A_RAM_TOP   6'h17
`define PPCE_A_NVM_TOP   6'h1b
`define PPCE_A_TMR       6'h1c
`define PPCE_A_NSUP      6'h1d
`define PPCE_A_IO        6'h1e
`define PPCE_A_VXI       6'h1f

`endif

// >>> verilog/ppce_engine.v
`timescale 1ns/1ns
`default_nettype none
`include "ppce_defs.vh"

module ppce_engine (
  input  wire        clk_sys_i,    // System clock, 100 MHz.
  input  wire        reset_i,      // Synchronous reset, active high.
  input  wire        nv_erase_i,   // Marks all stored locations empty except one saved in the same cycle.
  input  wire        cmd_valid_i,  // Command present.
  input  wire [4:0]  cmd_op_i,     // Command opcode.
  input  wire [3:0]  cmd_port_i,   // Port, location or line number.
  input  wire [6:0]  cmd_idx_i,    // Bit number or list index.
  input  wire [7:0]  cmd_data_i,   // Command value.
  input  wire        cmd_io_i,     // Scanlist direction flag.
  output reg         cmd_ready_o,  // Engine accepts a command.
  output reg         rsp_valid_o,  // Query answer pulse.
  output reg  [7:0]  rsp_data_o,   // Query answer.
  input  wire [95:0] port_in_i,    // Levels read from the ports.
  output reg  [95:0] port_out_o,   // Levels driven on the ports.
  input  wire [7:0]  trig_in_i,    // Trigger bus lines in.
  output reg  [7:0]  trig_out_o,   // Trigger bus pulse out.
  input  wire [7:0]  stb_i,        // Status byte.
  output reg         req_true_o,   // Request-true event pulse.
  output reg  [31:0] elapsed_o,    // Elapsed cycle count.
  input  wire [23:0] loc_addr_i,   // Local bus address.
  input  wire        loc_rd_i,     // Local read strobe.
  input  wire        loc_wr_i,     // Local write strobe.
  input  wire [7:0]  loc_wdata_i,  // Local write data.
  output reg  [7:0]  loc_rdata_o,  // Local read data.
  output reg         loc_ack_o,    // Local access done pulse.
  output reg         loc_err_o     // Access hit an unmapped hole.
);

  // ----------------------------------------------------------------
  // States and storage
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_PULSE = 4'b0010;
  localparam [3:0] ST_INIT  = 4'b0100;
  localparam [3:0] ST_TEST  = 4'b1000;

  reg [3:0]  state_r;
  reg [95:0] nv_mem [0:9];
  reg [9:0]  nv_valid_r;
  reg [7:0]  opt_mem [0:79];
  reg [9:0]  sl_mem [0:95];
  reg [7:0]  res_mem [0:95];
  reg [3:0]  sl_len_r [0:11];
  reg [3:0]  sl_ptr_r [0:11];
  reg [3:0]  res_cnt_r [0:11];
  reg [11:0] halt_r;
  reg        scan_en_r;
  reg        scan_cont_r;
  reg        scan_src_r;
  reg [15:0] dly_r;
  reg [15:0] dly_cnt_r;
  reg [3:0]  trg_in_sel_r;
  reg [3:0]  trg_out_sel_r;
  reg [7:0]  trg_in_q_r;
  reg [7:0]  sre_r;
  reg        srq_prev_r;
  reg [6:0]  pulse_bit_r;
  reg        pulse_lvl_r;
  reg [2:0]  tst_step_r;
  reg [7:0]  tst_fail_r;
  reg [31:0] tst_t0_r;
  reg        advance;
  integer    p;

  wire [3:0] region;
  wire       srq_now = |(stb_i & sre_r & `PPCE_SRE_B6_MASK);
  wire       cmd_take = cmd_valid_i & cmd_ready_o;

  // Index of entry k of port n in the flat scan memories.
  function [6:0] sl_addr;
    input [3:0] n;
    input [3:0] k;
    begin
      sl_addr = {n[3:0], 3'h0} + {3'h0, k};
    end
  endfunction

  // True when a line select names a live trigger line.
  function trg_on;
    input [3:0] sel;
    begin
      trg_on = (sel < `PPCE_TRG_OFF);
    end
  endfunction

  ppce_addr_dec u_dec (
    .addr_i   (loc_addr_i),
    .region_o (region)
  );

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  // External scanning follows the rising edge of the selected input line;
  // internal scanning paces itself on the programmed delay so that the
  // command port stays free between steps.
  always @* begin
    advance = 1'b0;
    if (cmd_take && cmd_op_i == `PPCE_OP_TRG && scan_en_r) begin
      advance = 1'b1;
    end else if (scan_en_r && scan_src_r == `PPCE_SRC_EXT) begin
      if (trg_on(trg_in_sel_r)) begin
        advance = trig_in_i[trg_in_sel_r[2:0]] & ~trg_in_q_r[trg_in_sel_r[2:0]];
      end
    end else if (scan_en_r && dly_cnt_r == 16'h0000) begin
      advance = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    rsp_valid_o <= 1'b0;
    req_true_o  <= 1'b0;
    trig_out_o  <= 8'h00;
    loc_ack_o   <= 1'b0;
    loc_err_o   <= 1'b0;
    trg_in_q_r  <= trig_in_i;
    srq_prev_r  <= srq_now;
    elapsed_o   <= elapsed_o + 32'h1;
    if (nv_erase_i) begin
      nv_valid_r <= 10'h000;
    end
    if (reset_i) begin
      state_r       <= ST_INIT;
      cmd_ready_o   <= 1'b0;
      rsp_data_o    <= 8'h00;
      port_out_o    <= 96'h0;
      elapsed_o     <= 32'h0;
      scan_en_r     <= 1'b0;
      scan_cont_r   <= 1'b0;
      scan_src_r    <= 1'b0;
      dly_r         <= 16'h0000;
      dly_cnt_r     <= 16'h0000;
      trg_in_sel_r  <= `PPCE_TRG_OFF;
      trg_out_sel_r <= `PPCE_TRG_OFF;
      sre_r         <= 8'h00;
      srq_prev_r    <= 1'b0;
      halt_r        <= 12'h000;
      pulse_bit_r   <= 7'h00;
      pulse_lvl_r   <= 1'b0;
      tst_step_r    <= 3'h0;
      tst_fail_r    <= 8'h00;
      tst_t0_r      <= 32'h0;
      for (p = 0; p < `PPCE_NPORT; p = p + 1) begin
        sl_len_r[p]  <= 4'h0;
        sl_ptr_r[p]  <= 4'h0;
        res_cnt_r[p] <= 4'h0;
      end
    end else begin
      // A rising match between status and enable raises one event.
      if (srq_now && !srq_prev_r) begin
        req_true_o <= 1'b1;
      end
      // Internal pacing counter reloads on every step it causes.
      if (scan_en_r) begin
        dly_cnt_r <= (dly_cnt_r == 16'h0000) ? dly_r : dly_cnt_r - 16'h0001;
      end
      // One scan step moves every port that is not halted and has entries left; in continuous mode a finished list wraps to its start.
      if (advance) begin
        if (trg_on(trg_out_sel_r)) begin
          trig_out_o[trg_out_sel_r[2:0]] <= 1'b1;
        end
        for (p = 0; p < `PPCE_NPORT; p = p + 1) begin
          if (sl_ptr_r[p] < sl_len_r[p] && !halt_r[p]) begin
            sl_ptr_r[p] <= sl_ptr_r[p] + 4'h1;
            if (sl_mem[sl_addr(p[3:0], sl_ptr_r[p])][9]) begin
              halt_r[p] <= 1'b1;
            end else if (sl_mem[sl_addr(p[3:0], sl_ptr_r[p])][8] == `PPCE_IO_OUT) begin
              port_out_o[p*8 +: 8] <= sl_mem[sl_addr(p[3:0], sl_ptr_r[p])][7:0];
            end else if (res_cnt_r[p] < `PPCE_SL_DEPTH) begin
              res_mem[sl_addr(p[3:0], res_cnt_r[p])] <=
                port_in_i[p*8 +: 8] & sl_mem[sl_addr(p[3:0], sl_ptr_r[p])][7:0];
              res_cnt_r[p] <= res_cnt_r[p] + 4'h1;
            end
          end else if (sl_ptr_r[p] == sl_len_r[p] && scan_cont_r && sl_len_r[p] != 4'h0) begin
            sl_ptr_r[p] <= 4'h0;
          end
        end
      end
      // Local bus: only the I/O window reaches a port; holes are inert.
      if (loc_rd_i || loc_wr_i) begin
        loc_ack_o <= 1'b1;
        loc_err_o <= (region == `PPCE_RG_NONE);
        loc_rdata_o <= 8'h00;
        if (region == `PPCE_RG_IO && loc_addr_i[3:0] < `PPCE_NPORT) begin
          if (loc_wr_i) begin
            port_out_o[loc_addr_i[3:0]*8 +: 8] <= loc_wdata_i;
          end else begin
            loc_rdata_o <= port_in_i[loc_addr_i[3:0]*8 +: 8];
          end
        end else if (region == `PPCE_RG_NVM && loc_addr_i[6:0] < `PPCE_OPT_LEN) begin
          if (loc_wr_i) begin
            opt_mem[loc_addr_i[6:0]] <= loc_wdata_i;
          end else begin
            loc_rdata_o <= opt_mem[loc_addr_i[6:0]];
          end
        end
      end
      case (state_r)
        // Power-up and reset load ports from location 0 when it holds data.
        ST_INIT: begin
          if (nv_valid_r[0]) begin
            port_out_o <= nv_mem[0];
          end
          cmd_ready_o <= 1'b1;
          state_r     <= ST_IDLE;
        end
        // Second half of a pulse; commands stay held off until it ends.
        ST_PULSE: begin
          port_out_o[pulse_bit_r] <= ~pulse_lvl_r;
          cmd_ready_o <= 1'b1;
          state_r     <= ST_IDLE;
        end
        // Self-test steps: only the timer is checked, at step 4; step 5 reports the failures.
        ST_TEST: begin
          tst_step_r <= tst_step_r + 3'h1;
          if (tst_step_r == `PPCE_TST_STEPS - 3'h1) begin
            if (elapsed_o == tst_t0_r) begin
              tst_fail_r[4] <= 1'b1;
            end
          end else if (tst_step_r == `PPCE_TST_STEPS) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= tst_fail_r;
            cmd_ready_o <= 1'b1;
            state_r     <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_take) begin
            case (cmd_op_i)
              `PPCE_OP_SETBIT: port_out_o[{cmd_port_i, 3'h0} + cmd_idx_i[2:0]] <= 1'b1;
              `PPCE_OP_CLRBIT: port_out_o[{cmd_port_i, 3'h0} + cmd_idx_i[2:0]] <= 1'b0;
              `PPCE_OP_OUTPORT: port_out_o[cmd_port_i*8 +: 8] <= cmd_data_i;
              `PPCE_OP_PULSEHI, `PPCE_OP_PULSELO: begin
                pulse_lvl_r <= (cmd_op_i == `PPCE_OP_PULSEHI);
                pulse_bit_r <= {cmd_port_i, 3'h0} + {4'h0, cmd_idx_i[2:0]};
                port_out_o[{cmd_port_i, 3'h0} + cmd_idx_i[2:0]] <= (cmd_op_i == `PPCE_OP_PULSEHI);
                cmd_ready_o <= 1'b0;
                state_r     <= ST_PULSE;
              end
              `PPCE_OP_RECALL: begin
                if (cmd_port_i <= `PPCE_LOC_LAST && nv_valid_r[cmd_port_i]) begin
                  port_out_o <= nv_mem[cmd_port_i];
                end
              end
              `PPCE_OP_SAVE: begin
                if (cmd_port_i <= `PPCE_LOC_LAST) begin
                  nv_mem[cmd_port_i]     <= port_out_o;
                  nv_valid_r[cmd_port_i] <= 1'b1;
                end
              end
              `PPCE_OP_RST: begin
                scan_en_r     <= 1'b0;
                trg_in_sel_r  <= `PPCE_TRG_OFF;
                trg_out_sel_r <= `PPCE_TRG_OFF;
                halt_r        <= 12'h000;
                for (p = 0; p < `PPCE_NPORT; p = p + 1) begin
                  sl_len_r[p]  <= 4'h0;
                  sl_ptr_r[p]  <= 4'h0;
                  res_cnt_r[p] <= 4'h0;
                end
                cmd_ready_o <= 1'b0;
                state_r     <= ST_INIT;
              end
              `PPCE_OP_TIMERST: elapsed_o <= 32'h0;
              `PPCE_OP_SCAN: begin
                scan_en_r   <= (cmd_data_i != `PPCE_SCAN_STOP);
                scan_cont_r <= (cmd_data_i == `PPCE_SCAN_CONT);
                dly_cnt_r   <= dly_r;
                if (cmd_data_i == `PPCE_SCAN_START) begin
                  halt_r <= 12'h000;
                end
              end
              // Appends land after the current tail of that port; once it holds 8 entries they are dropped.
              `PPCE_OP_SBREAK, `PPCE_OP_SLIST: begin
                if (cmd_port_i < `PPCE_NPORT && sl_len_r[cmd_port_i] < `PPCE_SL_DEPTH) begin
                  sl_mem[sl_addr(cmd_port_i, sl_len_r[cmd_port_i])] <=
                    {cmd_op_i == `PPCE_OP_SBREAK, cmd_io_i, cmd_data_i};
                  sl_len_r[cmd_port_i] <= sl_len_r[cmd_port_i] + 4'h1;
                end
              end
              `PPCE_OP_SCLEAR: begin
                if (cmd_port_i < `PPCE_NPORT) begin
                  sl_len_r[cmd_port_i]  <= 4'h0;
                  sl_ptr_r[cmd_port_i]  <= 4'h0;
                  res_cnt_r[cmd_port_i] <= 4'h0;
                  halt_r[cmd_port_i]    <= 1'b0;
                end
              end
              `PPCE_OP_SSIZE: begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= (cmd_port_i < `PPCE_NPORT) ? {4'h0, res_cnt_r[cmd_port_i]} : 8'h00;
              end
              `PPCE_OP_SREAD: begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= res_mem[sl_addr(cmd_port_i, {1'b0, cmd_idx_i[2:0]})];
              end
              `PPCE_OP_SSRC:   scan_src_r <= cmd_data_i[0];
              `PPCE_OP_DELAY:  dly_r <= {8'h00, cmd_data_i};
              `PPCE_OP_SRE_WR: sre_r <= cmd_data_i & `PPCE_SRE_B6_MASK;
              `PPCE_OP_SRE_RD: begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= sre_r & `PPCE_SRE_B6_MASK;
              end
              `PPCE_OP_TRGIN: begin
                if (cmd_port_i <= `PPCE_TRG_OFF) begin
                  trg_in_sel_r <= cmd_port_i;
                end
              end
              `PPCE_OP_TRGOUT: begin
                if (cmd_port_i <= `PPCE_TRG_OFF) begin
                  trg_out_sel_r <= cmd_port_i;
                end
              end
              `PPCE_OP_OPT_WR: begin
                if (cmd_idx_i < `PPCE_OPT_LEN) begin
                  opt_mem[cmd_idx_i] <= cmd_data_i;
                end
              end
              `PPCE_OP_OPT_RD: begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= (cmd_idx_i < `PPCE_OPT_LEN) ? opt_mem[cmd_idx_i] : 8'h00;
              end
              `PPCE_OP_TST: begin
                tst_step_r  <= 3'h0;
                tst_fail_r  <= 8'h00;
                tst_t0_r    <= elapsed_o;
                cmd_ready_o <= 1'b0;
                state_r     <= ST_TEST;
              end
              // Every command finishes before the next is taken, so the
              // wait has nothing left to hold and completes here.
              `PPCE_OP_WAI: cmd_ready_o <= 1'b1;
              default: cmd_ready_o <= 1'b1;
            endcase
          end
        end
        default: begin
          cmd_ready_o <= 1'b1;
          state_r     <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire
